// File: design/fail_judge.sv
// decides the fault condition from the failed-light vector of a row
`timescale 1ns/100ps
`include "guard_map.svh"

module fail_judge (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// link to the core
	guard_if.judge lnk
);
	guard_pkg::judge_state_t st;
	guard_pkg::judge_state_t next_st;
	logic [`CNT_W-1:0] total;
	logic adjacent;

	always_comb begin
		next_st = st;
		total = '0;
		for (int i = 0; i < `NUM_LIGHTS; i++) begin
			total = total + {{(`CNT_W-1){1'b0}}, lnk.failed[i]};
		end
		adjacent = |(lnk.failed[`NUM_LIGHTS-2:0]
			& lnk.failed[`NUM_LIGHTS-1:1]);
		// follows the condition only, never a reset input
		next_st.fault = adjacent || total >= `FAULT_TOTAL;
		next_st.fail_count = total;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign lnk.fault = st.fault;
	assign lnk.fail_count = st.fail_count;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_fault_adjacent: assert property (
		|($past(lnk.failed[`NUM_LIGHTS-2:0])
		& $past(lnk.failed[`NUM_LIGHTS-1:1])) |-> lnk.fault)
		else $error("two adjacent failures without fault");
	a_fault_clean: assert property (
		$past(lnk.failed) == '0 |-> !lnk.fault && lnk.fail_count == '0)
		else $error("fault with no failed light");
endmodule : fail_judge

// File: design/flash_timer.sv
// half-cycle divider for the alternating flash, plus a one-second tick
`timescale 1ns/100ps
`include "guard_map.svh"

module flash_timer (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// link to the core
	guard_if.timer lnk
);
	guard_pkg::timer_state_t st;
	guard_pkg::timer_state_t next_st;
	logic [`DATA_W-1:0] last;
	logic [`DATA_W-1:0] half_len;

	always_comb begin
		next_st = st;
		next_st.sec_tick = 1'b0;
		last = (lnk.half_period == '0) ? '0 : lnk.half_period - 1'b1;
		if (!lnk.run) begin
			next_st.cnt = '0;
			next_st.phase = 1'b0;
		end else if (st.cnt >= last) begin
			// both sets swap on one edge, so their halves are equal
			next_st.cnt = '0;
			next_st.phase = ~st.phase;
		end else begin
			next_st.cnt = st.cnt + 1'b1;
		end
		if (st.sec_cnt >= lnk.sec_cycles - 1'b1) begin
			next_st.sec_cnt = '0;
			next_st.sec_tick = 1'b1;
		end else begin
			next_st.sec_cnt = st.sec_cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign lnk.phase = st.phase;
	assign lnk.sec_tick = st.sec_tick;

	// cycles spent in the current half
	always_ff @(posedge core_clk) begin
		if (srst || !lnk.run || st.phase != next_st.phase) begin
			half_len <= '0;
		end else begin
			half_len <= half_len + 1'b1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_half_length: assert property (
		lnk.run && $past(lnk.run) && st.phase != next_st.phase
		&& lnk.half_period > 1 && $stable(lnk.half_period)
		|-> half_len == lnk.half_period - 1'b1)
		else $error("flash half cycle has the wrong length");
endmodule : flash_timer

// File: design/guard_if.sv
// links between the core, the flash timer and the failure judge
`timescale 1ns/100ps
`include "guard_map.svh"

interface guard_if;
	logic run;
	logic [`DATA_W-1:0] half_period;
	logic [`DATA_W-1:0] sec_cycles;
	logic phase;
	logic sec_tick;
	logic [`NUM_LIGHTS-1:0] failed;
	logic fault;
	logic [`CNT_W-1:0] fail_count;

	modport core (output run, half_period, sec_cycles, failed,
		input phase, sec_tick, fault, fail_count);
	modport timer (input run, half_period, sec_cycles,
		output phase, sec_tick);
	modport judge (input failed, output fault, fail_count);
endinterface : guard_if

// File: design/guard_light_flasher_monitor.sv
// What this block does
// - one closed contact switches on every guard light on the regulator.
// - when on goes active, all lights switch on and pulse unaided.
// - even lights pulse together, odd lights pulse as even ones go out.
// - each set is powered for half of every cycle, within half percent.
// - flash rate stays 30 to 32 per minute at every brightness.
// - caution rises on any failed light, control device or I/O module.
// - fault rises on two adjacent or three total failed lights in a row.
// - caution clears only by the maintenance reset contact.
// - after a reset, a later new failure raises caution again.
// - fault stays until the failure is gone; reset cannot clear it.
// - caution is active whenever fault is active.
// - one failed lamp leaves the rest of the row pulsing normally.
// - on loss of control link, pulsing continues for eight hours.
// - lights of one set switch together, well within 0.05 second.
// - even set runs opposite the odd set, within 0.13 second.
// - failed control device forces its lamps off; counts as component.
// - lost link to a control device is a communication failure.
// - segments switch by commands to control devices over carrier.
`timescale 1ns/100ps
`include "guard_map.svh"

module guard_light_flasher_monitor #(
	parameter logic [`DATA_W-1:0] HALF_CYCLES = `DATA_W'(
		(64'(`SEC_PER_MIN) * `CLK_HZ) / (64'(`FLASH_PER_MIN) * 64'd2)),
	parameter logic [`DATA_W-1:0] SEC_CYCLES = `DATA_W'(`CLK_HZ),
	parameter logic [`HOLD_W-1:0] HOLD_SECONDS = `HOLD_W'(
		`COMM_HOLD_HOURS * `SEC_PER_HOUR)
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// contacts from the vault computer and maintenance
	input wire logic on_contact,
	input wire logic caution_reset_contact,
	input wire logic ctrl_link_ok,
	// monitoring of the row
	input wire logic [`NUM_LIGHTS-1:0] lamp_fail,
	input wire logic [`NUM_LIGHTS-1:0] lcd_fail,
	input wire logic [`NUM_LIGHTS-1:0] xfmr_fail,
	input wire logic [`NUM_LIGHTS-1:0] lcd_comm_ok,
	input wire logic io_module_fail,
	// light commands and alarm contacts
	output logic [`NUM_LIGHTS-1:0] lamp_on,
	output logic caution_out,
	output logic fault_out,
	output logic comm_fail_out,
	// register port
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [`DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`DATA_W-1:0] reg_rdata
);
	guard_pkg::core_state_t st;
	guard_pkg::core_state_t next_st;
	guard_if lnk ();

	logic [`NUM_LIGHTS-1:0] failed;
	logic [`NUM_LIGHTS:0] fail_all;
	logic new_fail;
	logic hold_over;
	logic run_req;
	logic [`DATA_W-1:0] status_word;
	logic [`DATA_W-1:0] fail_word;

	flash_timer u_timer (
		.core_clk(core_clk),
		.srst(srst),
		.lnk(lnk)
	);

	fail_judge u_judge (
		.core_clk(core_clk),
		.srst(srst),
		.lnk(lnk)
	);

	// lamp, device and transformer all count as component failures
	assign failed = lamp_fail | lcd_fail | xfmr_fail;
	assign fail_all = {io_module_fail, failed};
	assign new_fail = |(fail_all & ~st.acked);
	assign hold_over = st.hold_cnt >= HOLD_SECONDS;
	// the one contact feeds the whole row
	assign run_req = on_contact && st.ctrl_en;

	assign lnk.run = st.running;
	assign lnk.half_period = st.half_period;
	assign lnk.sec_cycles = SEC_CYCLES;
	assign lnk.failed = failed;

	always_comb begin
		status_word = '0;
		status_word[`ST_RUNNING] = st.running;
		status_word[`ST_PHASE] = lnk.phase;
		status_word[`ST_CAUTION] = st.caution;
		status_word[`ST_FAULT] = st.fault;
		status_word[`ST_COMM_FAIL] = st.comm_fail;
		status_word[`ST_LINK_LOST] = st.link_lost;
		status_word[`ST_HOLD_OVER] = hold_over;
		fail_word = '0;
		fail_word[`FAIL_LO +: `NUM_LIGHTS] = failed;
		fail_word[`COMM_LO +: `NUM_LIGHTS] = ~lcd_comm_ok;
		fail_word[`IO_FAIL_BIT] = io_module_fail;
	end

	always_comb begin
		next_st = st;
		next_st.rdata = '0;

		// register writes
		if (reg_wr) begin
			unique case (reg_addr)
				`REG_CTRL: next_st.ctrl_en = reg_wdata[`CTRL_EN_BIT];
				`REG_HALF: next_st.half_period = reg_wdata;
				default: ;
			endcase
		end

		// register reads, answered in the next cycle only
		if (reg_rd) begin
			unique case (reg_addr)
				`REG_CTRL: next_st.rdata = {{(`DATA_W-1){1'b0}}, st.ctrl_en};
				`REG_STATUS: next_st.rdata = status_word;
				`REG_FAIL: next_st.rdata = fail_word;
				`REG_HALF: next_st.rdata = st.half_period;
				default: next_st.rdata = '0;
			endcase
		end

		// run control, held through a link loss for the hold time
		next_st.link_lost = !ctrl_link_ok;
		if (ctrl_link_ok) begin
			next_st.running = run_req;
			next_st.hold_cnt = '0;
		end else if (hold_over) begin
			next_st.running = 1'b0;
		end else begin
			next_st.running = st.running;
			if (lnk.sec_tick) begin
				next_st.hold_cnt = st.hold_cnt + 1'b1;
			end
		end

		// one phase bit for all lights: sets switch on the same edge
		for (int i = 0; i < `NUM_LIGHTS; i++) begin
			next_st.lamp_on[i] = st.running && (lnk.phase == i[0])
				&& !lcd_fail[i];
		end

		// caution: sticky, set beats the maintenance clear
		// a clear during a fault is refused, so caution outlives the fault
		next_st.sticky = new_fail
			|| (st.sticky
			&& !(caution_reset_contact && !lnk.fault));
		// last failure set: a new failure is a bit that rises
		next_st.acked = fail_all;
		next_st.fault = lnk.fault;
		next_st.caution = next_st.sticky || lnk.fault;
		next_st.comm_fail = ~&lcd_comm_ok;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '0;
			st.ctrl_en <= `CTRL_RESET;
			st.half_period <= HALF_CYCLES;
		end else begin
			st <= next_st;
		end
	end

	assign lamp_on = st.lamp_on;
	assign caution_out = st.caution;
	assign fault_out = st.fault;
	assign comm_fail_out = st.comm_fail;
	assign reg_rdata = st.rdata;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence seq_caution_ack;
		caution_reset_contact && !new_fail && !lnk.fault;
	endsequence

	sequence seq_later_fail;
		!caution_reset_contact && new_fail;
	endsequence

	sequence seq_on_request;
		ctrl_link_ok && run_req;
	endsequence

	sequence seq_off_request;
		ctrl_link_ok && !run_req;
	endsequence

	sequence seq_link_down;
		!ctrl_link_ok && !hold_over;
	endsequence

	sequence seq_hold_spent;
		!ctrl_link_ok && hold_over;
	endsequence

	sequence seq_write_half;
		reg_wr && reg_addr == `REG_HALF;
	endsequence

	a_start_pulse: assert property (
		$rose(st.running)
		|-> ##1 lamp_on == (`EVEN_MASK & ~$past(lcd_fail)))
		else $error("row did not start with the even set");

	a_sets_opposite: assert property (
		(lamp_on & `EVEN_MASK) != '0 |-> (lamp_on & `ODD_MASK) == '0)
		else $error("even and odd sets lit together");

	a_failed_dark: assert property (
		(lamp_on & $past(lcd_fail)) == '0)
		else $error("lamp lit behind a failed control device");

	a_idle_dark: assert property (
		!st.running ##1 !st.running |-> lamp_on == '0)
		else $error("lamp lit while row is off");

	a_caution_set: assert property (
		new_fail |-> ##1 caution_out)
		else $error("new failure did not raise caution");

	a_caution_clear: assert property (
		seq_caution_ack |-> ##1 !caution_out ##1 !fault_out)
		else $error("maintenance reset did not clear caution");

	a_caution_hold: assert property (
		caution_out && !caution_reset_contact |-> ##1 caution_out)
		else $error("caution dropped without reset contact");

	a_caution_rearm: assert property (
		seq_caution_ack ##1 seq_later_fail |-> ##1 caution_out)
		else $error("caution not raised again after reset");

	a_caution_fault: assert property (
		fault_out |-> caution_out)
		else $error("fault active without caution");

	a_fault_stays: assert property (
		fault_out && caution_reset_contact && lnk.fault |-> ##1 fault_out)
		else $error("reset contact cleared the fault");

	a_comm_hold: assert property (
		st.running && !ctrl_link_ok && !hold_over |-> ##1 st.running)
		else $error("pulsing stopped early after link loss");

	a_comm_fail: assert property (
		comm_fail_out == $past(~&lcd_comm_ok))
		else $error("communication failure flag wrong");

	a_read_once: assert property (
		!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside the answer cycle");

	a_lamp_pattern: assert property (
		lamp_on == ({`NUM_LIGHTS{$past(st.running)}} & ~$past(lcd_fail)
		& ($past(lnk.phase) ? `ODD_MASK : `EVEN_MASK)))
		else $error("lamp pattern differs from the phase");

	a_even_whole: assert property (
		(lamp_on & `EVEN_MASK) == '0
		|| (lamp_on & `EVEN_MASK) == (`EVEN_MASK & ~$past(lcd_fail)))
		else $error("even set did not switch as one");

	a_odd_whole: assert property (
		(lamp_on & `ODD_MASK) == '0
		|| (lamp_on & `ODD_MASK) == (`ODD_MASK & ~$past(lcd_fail)))
		else $error("odd set did not switch as one");

	a_run_on: assert property (
		seq_on_request |-> ##1 st.running)
		else $error("on request did not start the row");

	a_run_off: assert property (
		seq_off_request |-> ##1 !st.running)
		else $error("row kept running without the on contact");

	a_hold_stop: assert property (
		seq_hold_spent |-> ##1 !st.running)
		else $error("pulsing went on after the hold time");

	a_hold_clear: assert property (
		ctrl_link_ok |-> ##1 st.hold_cnt == '0)
		else $error("hold count kept while link is up");

	a_hold_frozen: assert property (
		!ctrl_link_ok && !st.running |-> ##1 !st.running)
		else $error("row started while link is lost");

	a_hold_count: assert property (
		seq_link_down ##0 !lnk.sec_tick |-> ##1 $stable(st.hold_cnt))
		else $error("hold count moved without a second tick");

	a_hold_step: assert property (
		seq_link_down ##0 lnk.sec_tick
		|-> ##1 st.hold_cnt == $past(st.hold_cnt) + 1'b1)
		else $error("hold count missed a second tick");

	a_link_flag: assert property (
		st.link_lost == $past(!ctrl_link_ok))
		else $error("link lost flag wrong");

	a_fault_follow: assert property (
		fault_out == $past(lnk.fault))
		else $error("fault output does not follow the condition");

	a_caution_keep: assert property (
		caution_reset_contact && lnk.fault |-> ##1 caution_out)
		else $error("reset contact cleared caution during a fault");

	a_caution_latch: assert property (
		new_fail && caution_reset_contact |-> ##1 caution_out)
		else $error("clear beat a new failure");

	a_caution_idle: assert property (
		!caution_out && !new_fail && !lnk.fault |-> ##1 !caution_out)
		else $error("caution raised with no new failure");

	a_half_write: assert property (
		seq_write_half |-> ##1 st.half_period == $past(reg_wdata))
		else $error("half period write lost");

	a_ctrl_write: assert property (
		reg_wr && reg_addr == `REG_CTRL
		|-> ##1 st.ctrl_en == $past(reg_wdata[`CTRL_EN_BIT]))
		else $error("control enable write lost");

	a_read_unmapped: assert property (
		reg_rd && reg_addr > `REG_HALF |-> ##1 reg_rdata == '0)
		else $error("unmapped read returned data");

	a_comm_pulse: assert property (
		!(&lcd_comm_ok) && st.running && lcd_fail == '0
		|-> ##1 lamp_on != '0)
		else $error("lamps dark on a control link loss");
endmodule : guard_light_flasher_monitor

// File: design/guard_map.svh
// register map, field positions, reset values and timing figures
`ifndef GUARD_MAP_SVH
`define GUARD_MAP_SVH

// widths
`define NUM_LIGHTS 8
`define CNT_W 4
`define HOLD_W 16
`define ADDR_W 4
`define DATA_W 32

// register indices
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_FAIL 4'h2
`define REG_HALF 4'h3

// control fields and reset value
`define CTRL_EN_BIT 0
`define CTRL_RESET 1'h1

// status fields
`define ST_RUNNING 0
`define ST_PHASE 1
`define ST_CAUTION 2
`define ST_FAULT 3
`define ST_COMM_FAIL 4
`define ST_LINK_LOST 5
`define ST_HOLD_OVER 6

// fail register fields
`define FAIL_LO 0
`define COMM_LO 8
`define IO_FAIL_BIT 16

// light sets
`define EVEN_MASK 8'h55
`define ODD_MASK 8'hAA
`define FAULT_TOTAL 4'h3

// timing figures in their own units
`define CLK_HZ 64'h0000_0000_05F5_E100
`define FLASH_PER_MIN 31
`define SEC_PER_MIN 60
`define COMM_HOLD_HOURS 8
`define SEC_PER_HOUR 3600

`endif

// File: design/guard_pkg.sv
// state types for the guard light flasher
package guard_pkg;
`include "guard_map.svh"

	typedef struct packed {
		logic ctrl_en;
		logic running;
		logic link_lost;
		logic [`HOLD_W-1:0] hold_cnt;
		logic [`DATA_W-1:0] half_period;
		logic [`NUM_LIGHTS:0] acked;
		logic sticky;
		logic caution;
		logic fault;
		logic comm_fail;
		logic [`NUM_LIGHTS-1:0] lamp_on;
		logic [`DATA_W-1:0] rdata;
	} core_state_t;

	typedef struct packed {
		logic [`DATA_W-1:0] cnt;
		logic phase;
		logic [`DATA_W-1:0] sec_cnt;
		logic sec_tick;
	} timer_state_t;

	typedef struct packed {
		logic fault;
		logic [`CNT_W-1:0] fail_count;
	} judge_state_t;

endpackage : guard_pkg

// File: verification/guard_light_flasher_monitor_tb_top.sv
// self-checking bench for the guard light flasher and monitor
`timescale 1ns/100ps
`include "guard_map.svh"

module guard_light_flasher_monitor_tb_top;
	localparam logic [31:0] HALF = 32'h0000_0008;
	typedef struct {string name; int what; logic [31:0] exp;} note_t;
	logic core_clk = 1'h0;
	logic srst;
	logic [7:0] lamp_fail;
	logic [7:0] lcd_fail;
	logic [7:0] xfmr_fail;
	logic [7:0] lcd_comm_ok;
	logic io_module_fail;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	wire on_contact, caution_reset_contact, ctrl_link_ok;
	logic [7:0] lamp_on;
	logic caution_out, fault_out, comm_fail_out;
	logic [31:0] reg_rdata;
	logic rd_q = 1'h0;
	logic probe = 1'h0;
	logic [7:0] last_lamp = 8'h00;
	logic [31:0] run_len = 32'h0000_0000;
	logic [31:0] rng = 32'h0b07_e8f9;
	logic [31:0] hw [3] = '{HALF, 32'h0000_0005, 32'h0000_0000};
	logic [31:0] he [3] = '{HALF, 32'h0000_0005, 32'h0000_0001};
	int failures = 0;
	int check_count = 0;
	note_t notes[$];
	logic [31:0] runs[$];

	vault_contacts vault_contacts_inst (
		.core_clk(core_clk),
		.on_contact(on_contact),
		.caution_reset_contact(caution_reset_contact),
		.ctrl_link_ok(ctrl_link_ok)
	);

	guard_light_flasher_monitor #(
		.HALF_CYCLES(HALF),
		.SEC_CYCLES(32'h0000_0004),
		.HOLD_SECONDS(16'h0006)
	) guard_light_flasher_monitor_inst (
		.core_clk(core_clk), .srst(srst),
		.on_contact(on_contact),
		.caution_reset_contact(caution_reset_contact),
		.ctrl_link_ok(ctrl_link_ok),
		.lamp_fail(lamp_fail), .lcd_fail(lcd_fail),
		.xfmr_fail(xfmr_fail), .lcd_comm_ok(lcd_comm_ok),
		.io_module_fail(io_module_fail),
		.lamp_on(lamp_on), .caution_out(caution_out),
		.fault_out(fault_out), .comm_fail_out(comm_fail_out),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
	);

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] xorshift(logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xorshift

	task chk(string name, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task complete_run;
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task cyc(int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task wr(logic [3:0] a, logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge core_clk);
		reg_wr <= 1'h0;
		@(posedge core_clk);
	endtask : wr

	task rd(logic [3:0] a, logic [31:0] e);
		notes.push_back('{"reg_rdata", 0, e});
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		@(posedge core_clk);
	endtask : rd

	// checks the output as it stands in the coming cycle
	task probe_out(string n, int what, logic [31:0] e);
		notes.push_back('{n, what, e});
		probe <= 1'h1;
		@(posedge core_clk);
		probe <= 1'h0;
		@(posedge core_clk);
	endtask : probe_out

	task wait_lamp(logic [7:0] e);
		for (int i = 0; i < 64 && lamp_on !== e; i++)
			@(posedge core_clk);
		chk("lamp_on wait", {24'h00_0000, e}, {24'h00_0000, lamp_on});
		if (lamp_on !== e)
			complete_run();
	endtask : wait_lamp

	always @(posedge core_clk)
		rd_q <= reg_rd;

	// pops the oldest note whenever a result stands
	always @(posedge core_clk) begin : watch
		note_t n;
		logic [31:0] seen;
		if (rd_q || probe) begin
			n = notes.pop_front();
			case (n.what)
				0: seen = reg_rdata;
				1: seen = {24'h00_0000, lamp_on};
				2: seen = {31'h0000_0000, caution_out};
				3: seen = {31'h0000_0000, fault_out};
				default: seen = {31'h0000_0000, comm_fail_out};
			endcase
			chk(n.name, n.exp, seen);
		end
		if (lamp_on !== last_lamp) begin
			if (runs.size() > 0)
				chk("half length", runs.pop_front(), run_len);
			run_len = 32'h0000_0001;
		end else
			run_len++;
		last_lamp = lamp_on;
	end

	initial begin
		logic [7:0] f;
		srst <= 1'h1;
		lamp_fail <= 8'h00;
		lcd_fail <= 8'h00;
		xfmr_fail <= 8'h00;
		lcd_comm_ok <= 8'hff;
		io_module_fail <= 1'h0;
		reg_addr <= 4'h0;
		reg_wdata <= 32'h0000_0000;
		reg_wr <= 1'h0;
		reg_rd <= 1'h0;
		repeat (5) @(posedge core_clk);
		srst <= 1'h0;
		@(posedge core_clk);
		rd(4'h0, 32'h0000_0001);
		rd(4'h3, HALF);
		rd(4'h1, 32'h0000_0000);
		rd(4'h7, 32'h0000_0000);
		wr(4'h1, 32'hffff_ffff);
		rd(4'h1, 32'h0000_0000);
		wr(4'h0, 32'h0000_0000);
		vault_contacts_inst.set_on(1'h1);
		cyc(4);
		probe_out("lamp_on", 1, 32'h0000_0000);
		wr(4'h0, 32'h0000_0001);
		wait_lamp(`EVEN_MASK);
		vault_contacts_inst.set_on(1'h0);
		cyc(4);
		vault_contacts_inst.set_on(1'h1);
		cyc(1);
		probe_out("lamp_on", 1, {24'h00_0000, `EVEN_MASK});
		for (int k = 0; k < 3; k++) begin
			wr(4'h3, hw[k]);
			wait_lamp(`EVEN_MASK);
			wait_lamp(`ODD_MASK);
			@(negedge core_clk);
			runs.push_back(he[k]);
			runs.push_back(he[k]);
			@(posedge core_clk);
			cyc(40);
			chk("runs left", 32'h0000_0000, 32'(runs.size()));
		end
		wr(4'h3, HALF);
		lcd_fail <= 8'h04;
		cyc(1);
		probe_out("caution", 2, 32'h0000_0001);
		wait_lamp(8'h51);
		wait_lamp(`ODD_MASK);
		vault_contacts_inst.press_reset();
		probe_out("caution", 2, 32'h0000_0000);
		xfmr_fail <= 8'h10;
		cyc(1);
		probe_out("caution", 2, 32'h0000_0001);
		probe_out("fault", 3, 32'h0000_0000);
		xfmr_fail <= 8'h00;
		lamp_fail <= 8'h08;
		cyc(2);
		probe_out("fault", 3, 32'h0000_0001);
		vault_contacts_inst.press_reset();
		probe_out("caution", 2, 32'h0000_0001);
		probe_out("fault", 3, 32'h0000_0001);
		lcd_fail <= 8'h00;
		lamp_fail <= 8'h00;
		cyc(2);
		probe_out("fault", 3, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			rng = xorshift(rng);
			f = (i == 0) ? 8'h15 : rng[7:0] & rng[15:8];
			lamp_fail <= f;
			cyc(2);
			probe_out("fault", 3,
				{31'h0000_0000, (|(f & (f >> 1))) || $countones(f) >= 3});
		end
		lamp_fail <= 8'h00;
		cyc(3);
		vault_contacts_inst.press_reset();
		probe_out("caution", 2, 32'h0000_0000);
		io_module_fail <= 1'h1;
		cyc(1);
		probe_out("caution", 2, 32'h0000_0001);
		probe_out("fault", 3, 32'h0000_0000);
		io_module_fail <= 1'h0;
		lcd_comm_ok <= 8'hf7;
		cyc(1);
		probe_out("comm_fail", 4, 32'h0000_0001);
		rd(4'h2, 32'h0000_0800);
		wait_lamp(`EVEN_MASK);
		lcd_comm_ok <= 8'hff;
		vault_contacts_inst.set_link(1'h0);
		vault_contacts_inst.set_on(1'h0);
		wait_lamp(`ODD_MASK);
		wait_lamp(`EVEN_MASK);
		cyc(40);
		probe_out("lamp_on", 1, 32'h0000_0000);
		vault_contacts_inst.set_on(1'h1);
		cyc(4);
		probe_out("lamp_on", 1, 32'h0000_0000);
		vault_contacts_inst.set_link(1'h1);
		wait_lamp(`EVEN_MASK);
		wait_lamp(`ODD_MASK);
		vault_contacts_inst.set_on(1'h0);
		cyc(1);
		probe_out("lamp_on", 1, 32'h0000_0000);
		complete_run();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		complete_run();
	end
endmodule : guard_light_flasher_monitor_tb_top

// File: verification/vault_contacts.sv
// contact model of the vault computer and maintenance panel
`timescale 1ns/100ps

module vault_contacts (
	// clock
	input wire logic core_clk,
	// contacts towards the block
	output logic on_contact,
	output logic caution_reset_contact,
	output logic ctrl_link_ok
);
	initial begin
		on_contact = 1'h0;
		caution_reset_contact = 1'h0;
		ctrl_link_ok = 1'h1;
	end

	task set_on(logic v);
		on_contact <= v;
		@(posedge core_clk);
	endtask : set_on

	task set_link(logic v);
		ctrl_link_ok <= v;
		@(posedge core_clk);
	endtask : set_link

	task press_reset;
		caution_reset_contact <= 1'h1;
		@(posedge core_clk);
		caution_reset_contact <= 1'h0;
	endtask : press_reset
endmodule : vault_contacts
